//--- shared/mpwm_defs.svh
// Register offsets, field positions, reset values and clock rate of the PWM unit
`ifndef MPWM_DEFS_SVH
`define MPWM_DEFS_SVH

`define MPWM_CLK_HZ          10000000
`define MPWM_OFS_PWR         8'h00
`define MPWM_OFS_PRESCALE    8'h04
`define MPWM_OFS_START       8'h08
`define MPWM_OFS_STOP        8'h0C
`define MPWM_OFS_ENABLE      8'h10
`define MPWM_OFS_MODE        8'h14
`define MPWM_OFS_OUTEN       8'h18
`define MPWM_OFS_OUTLVL      8'h1C
`define MPWM_OFS_OUTINV      8'h20
`define MPWM_OFS_OUTMODE     8'h24
`define MPWM_OFS_EVENTS      8'h28
`define MPWM_OFS_RELOAD0     8'h40
`define MPWM_OFS_COUNT0      8'h60
`define MPWM_OFS_STATFLAG0   8'h80
`define MPWM_NCH             3
`define MPWM_BIT_UNIT0       0
`define MPWM_BIT_UNIT1       1
`define MPWM_PS_A_LSB        0
`define MPWM_PS_B_LSB        4
`define MPWM_MODE_SEL_BIT    0
`define MPWM_RST_RELOAD      16'hFFFF
`define MPWM_RST_WORD        32'h0000_0000

`endif

//--- shared/mpwm_pkg.sv
// Types shared by the PWM unit files
package mpwm_pkg;
    typedef enum logic [1:0] {
        MPWM_IDLE = 2'b00,
        MPWM_RUN  = 2'b01,
        MPWM_DONE = 2'b11
    } mpwm_slave_e;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } mpwm_wb_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } mpwm_wb_rsp_s;

    typedef logic [15:0] mpwm_count_t;
endpackage

//--- hw/mpwm_prescaler.sv
// Prescaler that makes the two count-clock enable pulses
`timescale 1ns/1ps
`include "mpwm_defs.svh"

module mpwm_prescaler (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       run_i,
    input  wire logic [3:0] sel_a_i,
    input  wire logic [3:0] sel_b_i,
    output logic            tick_a_o,
    output logic            tick_b_o
);
    logic [15:0] div;
    logic [15:0] div_prev;

    // Free divider; a rising bit N gives a pulse every 2^(N+1) cycles
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            div      <= 16'h0000;
            div_prev <= 16'h0000;
        end else begin
            div      <= div + 16'h0001;
            div_prev <= div;
        end
    end

    // Select 0 passes the raw clock, so every cycle counts
    function automatic logic pick(input logic [3:0] s, input logic [15:0] d,
                                  input logic [15:0] dp, input logic run);
        if (!run) begin
            pick = 1'b0;
        end else if (s == 4'h0) begin
            pick = 1'b1;
        end else begin
            pick = d[s - 4'h1] && !dp[s - 4'h1];
        end
    endfunction

    assign tick_a_o = pick(sel_a_i, div, div_prev, run_i);
    assign tick_b_o = pick(sel_b_i, div, div_prev, run_i);
endmodule

//--- hw/mpwm_top.sv
// Multi-channel PWM unit: one master period channel, two duty slaves, Wishbone regs
//
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "mpwm_defs.svh"

module mpwm_top (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire mpwm_pkg::mpwm_wb_req_s wb_req_i,
    output mpwm_pkg::mpwm_wb_rsp_s      wb_rsp_o,
    output logic [2:0]                 timer_output_o,
    output logic [2:0]                 timer_output_oe_o,
    output logic                       master_period_irq_o,
    output logic [1:0]                 slave_done_irq_o
);
    localparam int NCH = `MPWM_NCH;

    logic [1:0]              peripheral_enable;
    logic [7:0]              clock_prescale_select;
    logic [NCH-1:0]          chan_enable_status;
    logic [NCH-1:0]          channel_mode_config;
    logic [NCH-1:0]          output_enable_bit;
    logic [NCH-1:0]          timer_output;
    logic [NCH-1:0]          output_level_invert;
    logic [NCH-1:0]          output_mode_select;
    mpwm_pkg::mpwm_count_t   reload_data  [NCH];
    mpwm_pkg::mpwm_count_t   down_counter [NCH];
    mpwm_pkg::mpwm_slave_e   slave_state  [NCH];
    logic [NCH-1:0]          count_level;
    logic [NCH-1:0]          event_seen;
    logic                    unit_on;
    logic                    tick_a;
    logic                    tick_b;
    logic [NCH-1:0]          tick;
    logic                    wr;
    logic                    rd_sel;
    logic                    soft_rst;
    logic                    start_wr;
    logic                    stop_wr;
    logic [NCH-1:0]          start_bits;
    logic [NCH-1:0]          stop_bits;
    logic                    master_start;
    logic                    master_wrap;
    logic                    period_evt;
    logic [31:0]             next_rdata;
    logic                    ack;
    logic [31:0]             rdata;

    assign unit_on  = peripheral_enable[`MPWM_BIT_UNIT0] | peripheral_enable[`MPWM_BIT_UNIT1];
    assign soft_rst = !unit_on;
    assign rd_sel   = wb_req_i.cyc && wb_req_i.stb && !ack;
    // Writes to channel registers are dropped while unpowered
    assign wr       = rd_sel && wb_req_i.we && wb_req_i.sel[0];
    assign start_wr = wr && unit_on && (wb_req_i.adr == `MPWM_OFS_START);
    assign stop_wr  = wr && unit_on && (wb_req_i.adr == `MPWM_OFS_STOP);
    assign start_bits = start_wr ? wb_req_i.dat[NCH-1:0] : '0;
    assign stop_bits  = stop_wr ? wb_req_i.dat[NCH-1:0] : '0;

    // Per-channel clock selection from the mode bit
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_tick
            assign tick[g] = channel_mode_config[g] ? tick_b : tick_a;
        end
    endgenerate

    mpwm_prescaler u_prescaler (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .run_i    (unit_on),
        .sel_a_i  (clock_prescale_select[3:0]),
        .sel_b_i  (clock_prescale_select[7:4]),
        .tick_a_o (tick_a),
        .tick_b_o (tick_b)
    );

    // Classic Wishbone: one-cycle ack, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack   <= 1'b0;
            rdata <= `MPWM_RST_WORD;
        end else begin
            ack   <= rd_sel;
            rdata <= next_rdata;
        end
    end
    assign wb_rsp_o.ack = ack;
    assign wb_rsp_o.dat = rdata;

    // Power enable is never gated by itself
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            peripheral_enable <= 2'b00;
        end else if (wr && wb_req_i.adr == `MPWM_OFS_PWR) begin
            peripheral_enable <= wb_req_i.dat[1:0];
        end
    end

    // Config registers; all wiped by power-off
    always_ff @(posedge clk_i) begin
        if (rst_i || soft_rst) begin
            clock_prescale_select <= 8'h00;
            channel_mode_config   <= '0;
            output_enable_bit     <= '0;
            timer_output          <= '0;
            output_level_invert   <= '0;
            output_mode_select    <= '0;
            for (int i = 0; i < NCH; i++) begin
                reload_data[i] <= `MPWM_RST_RELOAD;
            end
        end else if (wr) begin
            if (wb_req_i.adr == `MPWM_OFS_PRESCALE) begin
                clock_prescale_select <= wb_req_i.dat[7:0];
            end else if (wb_req_i.adr == `MPWM_OFS_MODE) begin
                channel_mode_config <= wb_req_i.dat[NCH-1:0];
            end else if (wb_req_i.adr == `MPWM_OFS_OUTEN) begin
                output_enable_bit <= wb_req_i.dat[NCH-1:0];
            end else if (wb_req_i.adr == `MPWM_OFS_OUTLVL) begin
                timer_output <= wb_req_i.dat[NCH-1:0];
            end else if (wb_req_i.adr == `MPWM_OFS_OUTINV) begin
                output_level_invert <= wb_req_i.dat[NCH-1:0];
            end else if (wb_req_i.adr == `MPWM_OFS_OUTMODE) begin
                output_mode_select <= wb_req_i.dat[NCH-1:0];
            end else begin
                for (int i = 0; i < NCH; i++) begin
                    if (wb_req_i.adr == `MPWM_OFS_RELOAD0 + 8'(4 * i)) begin
                        reload_data[i] <= wb_req_i.dat[15:0];
                    end
                end
            end
        end
    end

    // Enable status: stop beats start if both written together
    always_ff @(posedge clk_i) begin
        if (rst_i || soft_rst) begin
            chan_enable_status <= '0;
        end else begin
            chan_enable_status <= (chan_enable_status | start_bits) & ~stop_bits;
        end
    end

    // Master: start loads at once and fires the period event
    assign master_start = start_bits[0];
    assign master_wrap  = chan_enable_status[0] && tick[0] && (down_counter[0] == 16'h0000);
    assign period_evt   = master_start || master_wrap;

    always_ff @(posedge clk_i) begin
        if (rst_i || soft_rst) begin
            down_counter[0] <= 16'h0000;
        end else if (period_evt) begin
            down_counter[0] <= reload_data[0];
        end else if (chan_enable_status[0] && tick[0] && !stop_bits[0]) begin
            down_counter[0] <= down_counter[0] - 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || soft_rst) begin
            master_period_irq_o <= 1'b0;
        end else begin
            master_period_irq_o <= period_evt;
        end
    end

    // Slaves: one-count mode, loaded and armed by each period event while enabled or being started, and not being stopped
    generate
        for (g = 1; g < NCH; g++) begin : g_slave
            logic run_ok;
            assign run_ok = (chan_enable_status[g] || start_bits[g]) && !stop_bits[g];

            always_ff @(posedge clk_i) begin
                if (rst_i || soft_rst) begin
                    slave_state[g]  <= mpwm_pkg::MPWM_IDLE;
                    down_counter[g] <= 16'h0000;
                    count_level[g]  <= 1'b0;
                    event_seen[g]   <= 1'b0;
                end else if (period_evt && run_ok) begin
                    // Reload picked up only here, so a mid-period write waits
                    down_counter[g] <= reload_data[g];
                    event_seen[g]   <= 1'b1;
                    slave_state[g]  <= mpwm_pkg::MPWM_RUN;
                end else if (chan_enable_status[g] && !stop_bits[g] && tick[g]) begin
                    case (slave_state[g])
                        mpwm_pkg::MPWM_RUN: begin
                            if (event_seen[g]) begin
                                // First count after the event turns output on unless the loaded count is zero
                                event_seen[g]  <= 1'b0;
                                count_level[g] <= (down_counter[g] != 16'h0000);
                                if (down_counter[g] == 16'h0000) begin
                                    slave_state[g] <= mpwm_pkg::MPWM_DONE;
                                end else begin
                                    down_counter[g] <= down_counter[g] - 16'h0001;
                                end
                            end else if (down_counter[g] == 16'h0000) begin
                                count_level[g] <= 1'b0;
                                slave_state[g] <= mpwm_pkg::MPWM_DONE;
                            end else begin
                                down_counter[g] <= down_counter[g] - 16'h0001;
                            end
                        end
                        default: begin
                            // Done or idle: hold until the next period event
                            slave_state[g] <= slave_state[g];
                        end
                    endcase
                end
            end

            // Done pulse when the count reaches zero in run state
            always_ff @(posedge clk_i) begin
                if (rst_i || soft_rst) begin
                    slave_done_irq_o[g-1] <= 1'b0;
                end else begin
                    slave_done_irq_o[g-1] <= chan_enable_status[g] && !stop_bits[g] && tick[g]
                        && !period_evt && slave_state[g] == mpwm_pkg::MPWM_RUN
                        && down_counter[g] == 16'h0000;
                end
            end

            // Pin: counting level then polarity, or written level as it stands
            always_ff @(posedge clk_i) begin
                if (rst_i || soft_rst) begin
                    timer_output_o[g]    <= 1'b0;
                    timer_output_oe_o[g] <= 1'b0;
                end else begin
                    timer_output_oe_o[g] <= output_mode_select[g];
                    if (output_enable_bit[g]) begin
                        // Level held across a stop because count_level freezes
                        timer_output_o[g] <= count_level[g] ^ output_level_invert[g];
                    end else begin
                        timer_output_o[g] <= timer_output[g];
                    end
                end
            end
        end
    endgenerate

    // Master pin is never driven in this function
    assign timer_output_o[0]    = 1'b0;
    assign timer_output_oe_o[0] = 1'b0;
    assign slave_state[0] = mpwm_pkg::MPWM_IDLE;
    assign count_level[0] = 1'b0;
    assign event_seen[0]  = 1'b0;

    // Read mux; unmapped and status-flag words read zero
    always_comb begin
        next_rdata = `MPWM_RST_WORD;
        if (wb_req_i.adr == `MPWM_OFS_PWR) begin
            next_rdata = {30'h0, peripheral_enable};
        end else if (wb_req_i.adr == `MPWM_OFS_PRESCALE) begin
            next_rdata = {24'h0, clock_prescale_select};
        end else if (wb_req_i.adr == `MPWM_OFS_ENABLE) begin
            next_rdata = {29'h0, chan_enable_status};
        end else if (wb_req_i.adr == `MPWM_OFS_MODE) begin
            next_rdata = {29'h0, channel_mode_config};
        end else if (wb_req_i.adr == `MPWM_OFS_OUTEN) begin
            next_rdata = {29'h0, output_enable_bit};
        end else if (wb_req_i.adr == `MPWM_OFS_OUTLVL) begin
            next_rdata = {29'h0, timer_output};
        end else if (wb_req_i.adr == `MPWM_OFS_OUTINV) begin
            next_rdata = {29'h0, output_level_invert};
        end else if (wb_req_i.adr == `MPWM_OFS_OUTMODE) begin
            next_rdata = {29'h0, output_mode_select};
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (wb_req_i.adr == `MPWM_OFS_RELOAD0 + 8'(4 * i)) begin
                    next_rdata = {16'h0, reload_data[i]};
                end else if (wb_req_i.adr == `MPWM_OFS_COUNT0 + 8'(4 * i)) begin
                    next_rdata = {16'h0, down_counter[i]};
                end
            end
        end
    end

    // Assertions
    property p_start_evt;
        @(posedge clk_i) disable iff (rst_i)
        start_bits[0] |=> master_period_irq_o && chan_enable_status[0];
    endproperty
    a_start_evt: assert property (p_start_evt) else $error("start gave no period event");

    property p_wrap;
        @(posedge clk_i) disable iff (rst_i || soft_rst)
        master_wrap |=> down_counter[0] == $past(reload_data[0]) && master_period_irq_o;
    endproperty
    a_wrap: assert property (p_wrap) else $error("master reload missing");

    property p_stop;
        @(posedge clk_i) disable iff (rst_i)
        stop_bits != '0 |=> (chan_enable_status & $past(stop_bits)) == '0;
    endproperty
    a_stop: assert property (p_stop) else $error("stop left channel enabled");

    property p_freeze;
        @(posedge clk_i) disable iff (rst_i || soft_rst)
        !chan_enable_status[0] && !start_bits[0] |=> $stable(down_counter[0]);
    endproperty
    a_freeze: assert property (p_freeze) else $error("stopped counter moved");

    property p_power_off;
        @(posedge clk_i) disable iff (rst_i)
        soft_rst |=> chan_enable_status == '0 && timer_output == '0;
    endproperty
    a_power_off: assert property (p_power_off) else $error("power-off did not reset");

    property p_no_write_off;
        @(posedge clk_i) disable iff (rst_i)
        soft_rst && !(wr && wb_req_i.adr == `MPWM_OFS_PWR) |=> soft_rst && output_enable_bit == '0;
    endproperty
    a_no_write_off: assert property (p_no_write_off) else $error("write accepted unpowered");

    property p_master_pin;
        @(posedge clk_i) disable iff (rst_i)
        timer_output_oe_o[0] == 1'b0;
    endproperty
    a_master_pin: assert property (p_master_pin) else $error("master pin driven");

    property p_soft_level;
        @(posedge clk_i) disable iff (rst_i || soft_rst)
        !output_enable_bit[1] ##1 !output_enable_bit[1] |-> timer_output_o[1] == $past(timer_output[1]);
    endproperty
    a_soft_level: assert property (p_soft_level) else $error("pin not at written level");

    sequence s_slave_load;
        period_evt && chan_enable_status[1] && !stop_bits[1];
    endsequence
    property p_slave_load;
        @(posedge clk_i) disable iff (rst_i || soft_rst)
        s_slave_load |=> down_counter[1] == $past(reload_data[1]) && event_seen[1];
    endproperty
    a_slave_load: assert property (p_slave_load) else $error("slave did not reload");

    property p_ack;
        @(posedge clk_i) disable iff (rst_i)
        rd_sel |=> ack ##1 !ack;
    endproperty
    a_ack: assert property (p_ack) else $error("bus ack not one cycle");
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the multi-channel PWM unit over its Wishbone registers
`timescale 1ns/1ps
`include "mpwm_defs.svh"

module tb_top;
    logic                   clk_i;
    logic                   rst_i;
    mpwm_pkg::mpwm_wb_req_s wb_req;
    mpwm_pkg::mpwm_wb_rsp_s wb_rsp;
    logic [2:0]             tout;
    logic [2:0]             toe;
    logic                   irq;
    logic [1:0]             done;
    int                     errors;
    int                     checks_done;
    int                     cnt;
    int                     per;
    int                     hi2;
    int                     hi2p;
    int                     dc;
    int                     dcp;
    int                     dc2;
    int                     dc2p;
    int                     run1;
    int                     w1;
    int                     n;
    logic [31:0]            rq;
    logic [5:0]             hold;

    mpwm_top i_dut (
        .clk_i               (clk_i),
        .rst_i               (rst_i),
        .wb_req_i            (wb_req),
        .wb_rsp_o            (wb_rsp),
        .timer_output_o      (tout),
        .timer_output_oe_o   (toe),
        .master_period_irq_o (irq),
        .slave_done_irq_o    (done)
    );

    // 100 ns clock
    always #50 clk_i = ~clk_i;

    // Per-period monitor; a window of one period is phase-free for widths
    always @(posedge clk_i) begin
        if (tout[1] === 1'b1) begin
            run1 <= run1 + 1;
        end else if (run1 != 0) begin
            w1   <= run1;
            run1 <= 0;
        end
        if (irq === 1'b1) begin
            per  <= cnt;
            cnt  <= 1;
            hi2p <= hi2;
            hi2  <= int'(tout[2] === 1'b1);
            dcp  <= dc;
            dc   <= int'(done[0] === 1'b1);
            dc2p <= dc2;
            dc2  <= int'(done[1] === 1'b1);
        end else begin
            cnt <= cnt + 1;
            hi2 <= hi2 + int'(tout[2] === 1'b1);
            dc  <= dc + int'(done[0] === 1'b1);
            dc2 <= dc2 + int'(done[1] === 1'b1);
        end
    end

    task automatic print_verdict();
        if (errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Classic single cycle; answer latency is left to the slave
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: d};
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_rsp.ack !== 1'b1 && k < 50);
        q = wb_rsp.dat;
        if (k >= 50) errors++;
        wb_req <= '0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0000_0000, q);
        chk(nm, e, q);
    endtask

    task automatic wait_irq(output int k);
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (irq !== 1'b1 && k < 100);
        if (k >= 100) errors++;
    endtask

    // Skip the start-up period and one more, then judge one settled period
    task automatic measure(input int p, input int w, input int h2);
        int k;
        repeat (3) wait_irq(k);
        @(negedge clk_i);
        chk("period", p, per);
        chk("width1", w, w1);
        chk("high2", h2, hi2p);
        chk("done1", 1, dcp);
        chk("done2", 0, dc2p);
    endtask

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (10000) @(posedge clk_i);
        errors++;
        print_verdict();
    end

    initial begin
        clk_i  = 1'b0;
        rst_i  = 1'b1;
        wb_req = '0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wr(`MPWM_OFS_PRESCALE, 32'h0000_0011);
        rc("prescale_off", `MPWM_OFS_PRESCALE, 32'h0000_0000);
        rc("reload0_rst", `MPWM_OFS_RELOAD0, 32'h0000_FFFF);
        wr(`MPWM_OFS_PWR, 32'h0000_0001);
        rc("enable_idle", `MPWM_OFS_ENABLE, 32'h0000_0000);
        wr(`MPWM_OFS_PRESCALE, 32'h0000_0010);
        rc("prescale", `MPWM_OFS_PRESCALE, 32'h0000_0010);
        wr(`MPWM_OFS_MODE, 32'h0000_0000);
        wr(`MPWM_OFS_RELOAD0, 32'h0000_0009);
        wr(`MPWM_OFS_RELOAD0 + 8'h04, 32'h0000_0003);
        wr(`MPWM_OFS_RELOAD0 + 8'h08, 32'h0000_0014);
        wr(`MPWM_OFS_OUTMODE, 32'h0000_0006);
        wr(`MPWM_OFS_OUTINV, 32'h0000_0000);
        wr(`MPWM_OFS_OUTLVL, 32'h0000_0000);
        wr(`MPWM_OFS_OUTEN, 32'h0000_0006);
        @(negedge clk_i);
        chk("oe", 32'h0000_0006, toe);
        chk("pin_idle", 32'h0000_0000, tout);
        wr(`MPWM_OFS_START, 32'h0000_0007);
        // Start event already stands at the ack edge, before its NBA update
        chk("irq_start", 32'h0000_0001, irq);
        rc("start_clr", `MPWM_OFS_START, 32'h0000_0000);
        rc("enable_run", `MPWM_OFS_ENABLE, 32'h0000_0007);
        measure(10, 3, 10);
        wb(1'b0, `MPWM_OFS_COUNT0, 32'h0000_0000, rq);
        chk("count0_live", 32'h0000_0001, rq <= 9);
        // New duty written just after an event must wait for the next one
        wait_irq(n);
        wr(`MPWM_OFS_RELOAD0 + 8'h04, 32'h0000_0005);
        wait_irq(n);
        @(negedge clk_i);
        chk("width_old", 3, w1);
        wait_irq(n);
        @(negedge clk_i);
        chk("width_new", 5, w1);
        wr(`MPWM_OFS_STOP, 32'h0000_0007);
        rc("stop_clr", `MPWM_OFS_STOP, 32'h0000_0000);
        rc("enable_stop", `MPWM_OFS_ENABLE, 32'h0000_0000);
        wb(1'b0, `MPWM_OFS_COUNT0 + 8'h04, 32'h0000_0000, rq);
        @(negedge clk_i);
        hold = {toe, tout};
        repeat (20) @(posedge clk_i);
        rc("count1_frozen", `MPWM_OFS_COUNT0 + 8'h04, rq);
        @(negedge clk_i);
        chk("pin_hold", hold, {toe, tout});
        // Restart on clock b (two clocks per tick) with slave 1 inverted
        wr(`MPWM_OFS_RELOAD0 + 8'h04, 32'h0000_0003);
        wr(`MPWM_OFS_MODE, 32'h0000_0007);
        wr(`MPWM_OFS_OUTINV, 32'h0000_0002);
        wr(`MPWM_OFS_START, 32'h0000_0007);
        measure(20, 14, 20);
        wr(`MPWM_OFS_STOP, 32'h0000_0007);
        wr(`MPWM_OFS_OUTLVL, 32'h0000_0006);
        wr(`MPWM_OFS_OUTEN, 32'h0000_0000);
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk("pin_sw", 32'h0000_0006, tout);
        rc("statflag", `MPWM_OFS_STATFLAG0, 32'h0000_0000);
        rc("unmapped", 8'hFC, 32'h0000_0000);
        wr(`MPWM_OFS_PWR, 32'h0000_0000);
        rc("level_rst", `MPWM_OFS_OUTLVL, 32'h0000_0000);
        rc("reload0_rst2", `MPWM_OFS_RELOAD0, 32'h0000_FFFF);
        @(negedge clk_i);
        chk("pins_off", 32'h0000_0000, {toe, tout});
        print_verdict();
    end
endmodule
